// >>> logic/qcta_top.v
// Quad counter/timer array: two classic counter/timers and two auto-reload timers with capture.
// Function
// R1 - Four independent timers, each with a 16-bit count register.
// R2 - Timers 0/1: 13-bit, 16-bit, 8-bit reload; timer 0 also splits into two 8-bit.
// R3 - Timers 2/3: 16-bit auto-reload or two 8-bit auto-reload halves.
// R4 - Timers 2/3 capture count on edges of a measured clock source.
// R5 - Timers 0/1 clock from five sources via select bits and prescale field.
// R6 - Per-timer select bit picks prescaled clock or undivided system clock.
// R7 - Timers 2/3 count on system clock or system clock divided by twelve.
// R8 - Timer 2 may also count on RTC oscillator/8 or comparator zero.
// R9 - Timer 3 may also count on external oscillator/8 or comparator one.
// R10 - Counter mode increments once per falling edge on the event pin.
// R11 - Event rates up to a quarter of system clock are counted.
// R12 - Event source holds each level at least two system clock cycles.
// R13 - Prescale 00 sys/12, 01 sys/4, 10 sys/48, 11 external/8 synchronised.
// R14 - Timer 0/1 runs only when run set and gate clear or gate input active.
// R15 - Event inputs synchronised; falling edge gives exactly one increment pulse.
`timescale 1ns/10ps
`include "qcta_map.vh"
module qcta_top #(
    parameter PRE_W = 6
) (
    input  wire        mclk_in,
    input  wire        arst_n_in,
    input  wire        ce_in,
    input  wire        timer0_event_pin_in,
    input  wire        timer1_event_pin_in,
    input  wire        ext_clk_in,
    input  wire        rtc_osc_in,
    input  wire        xosc_clk_in,
    input  wire        cmp0_out_in,
    input  wire        cmp1_out_in,
    input  wire        prescale_sel_hi_in,
    input  wire        prescale_sel_lo_in,
    input  wire        timer0_sysclk_select_in,
    input  wire        timer1_sysclk_select_in,
    input  wire [1:0]  t01_mode_in,
    input  wire [1:0]  t1_mode_in,
    input  wire [1:0]  t01_counter_sel_in,
    input  wire        timer0_run_in,
    input  wire        timer1_run_in,
    input  wire        timer0_gate_enable_in,
    input  wire        timer1_gate_enable_in,
    input  wire        ext_gate_input0_in,
    input  wire        ext_gate_input1_in,
    input  wire [3:0]  load_in,
    input  wire [15:0] load_value_in,
    input  wire [1:0]  t23_run_in,
    input  wire [1:0]  t23_split_in,
    input  wire [1:0]  t23_capture_in,
    input  wire [1:0]  t23_sysclk_lo_in,
    input  wire [1:0]  t23_sysclk_hi_in,
    input  wire [3:0]  t23_src_sel_in,
    input  wire [31:0] t23_reload_in,
    output wire [63:0] count_out,
    output wire [3:0]  ovf_out,
    output wire [1:0]  t23_ovf_lo_out,
    output wire [31:0] t23_capture_out,
    output wire [1:0]  t23_capture_evt_out
);
    // Synchronisers: s1 feeds only s2; edges come from s2 against s3.
    wire [`QCTA_LANES-1:0] raw_in;
    reg  [`QCTA_LANES-1:0] s1_ff;
    reg  [`QCTA_LANES-1:0] s2_ff;
    reg  [`QCTA_LANES-1:0] s3_ff;
    wire [`QCTA_LANES-1:0] rise;
    wire [`QCTA_LANES-1:0] fall;
    assign raw_in = {cmp1_out_in, cmp0_out_in, xosc_clk_in, rtc_osc_in, ext_clk_in,
                     timer1_event_pin_in, timer0_event_pin_in};
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_ff <= {`QCTA_LANES{1'b0}};
            s2_ff <= {`QCTA_LANES{1'b0}};
            s3_ff <= {`QCTA_LANES{1'b0}};
        end else if (ce_in) begin
            s1_ff <= raw_in;   // see R15
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign rise = s2_ff & ~s3_ff;
    assign fall = s3_ff & ~s2_ff;   // see R15, see R11, see R12
    // Divide-by-eight of the external, RTC and external-oscillator clocks.
    wire [2:0] div8_tick;
    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_div8
            reg [2:0] d8_ff;
            always @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    d8_ff <= 3'h0;
                end else if (ce_in && rise[`QCTA_LN_EXT + k]) begin
                    d8_ff <= d8_ff + 3'h1;
                end
            end
            assign div8_tick[k] = rise[`QCTA_LN_EXT + k] && (d8_ff == 3'h7);   // see R8, see R9
        end
    endgenerate
    // System clock prescalers: a mod-48 counter gives /4 and /48, a mod-12 gives /12.
    reg  [PRE_W-1:0] p48_ff;
    reg  [3:0]       p12_ff;
    wire             tick4;
    wire             tick12;
    wire             tick48;
    reg              pre_tick;
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            p48_ff <= {PRE_W{1'b0}};
            p12_ff <= 4'h0;
        end else if (ce_in) begin
            p48_ff <= tick48 ? {PRE_W{1'b0}} : p48_ff + 1'b1;
            p12_ff <= tick12 ? 4'h0 : p12_ff + 4'h1;
        end
    end
    assign tick48 = (p48_ff == `QCTA_DIV_SYS48 - 1);
    assign tick4  = (p48_ff[1:0] == `QCTA_DIV_SYS4 - 1);
    assign tick12 = (p12_ff == `QCTA_DIV_SYS12 - 1);   // see R7
    always @* begin
        case ({prescale_sel_hi_in, prescale_sel_lo_in})   // see R13
            `QCTA_PRE_SYS12: pre_tick = tick12;
            `QCTA_PRE_SYS4:  pre_tick = tick4;
            `QCTA_PRE_SYS48: pre_tick = tick48;
            default:         pre_tick = div8_tick[0];
        endcase
    end
    // Timers 0 and 1.
    wire [1:0] sys_sel;
    wire [1:0] run_bit;
    wire [1:0] gate_en;
    wire [1:0] gate_in;
    wire [3:0] mode01;
    wire       split0;
    wire       split_hi_ovf;
    wire [1:0] own_ovf;
    wire [31:0] cnt01;
    assign sys_sel = {timer1_sysclk_select_in, timer0_sysclk_select_in};
    assign run_bit = {timer1_run_in, timer0_run_in};
    assign gate_en = {timer1_gate_enable_in, timer0_gate_enable_in};
    assign gate_in = {ext_gate_input1_in, ext_gate_input0_in};
    assign mode01  = {t1_mode_in, t01_mode_in};
    assign split0  = (t01_mode_in == `QCTA_MODE_SPLIT);
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_t01
            reg  [15:0] cnt_ff;
            reg  [15:0] nxt_cnt;
            reg         ovf_ff;
            reg         nxt_ovf;
            reg         hovf_ff;
            reg         nxt_hovf;
            wire [1:0]  md;
            wire        run;
            wire        tick;
            wire        htick;
            wire        split_me;
            assign md       = mode01[2*i+1:2*i];
            assign run      = run_bit[i] && (!gate_en[i] || gate_in[i]);   // see R14
            assign tick     = t01_counter_sel_in[i] ? fall[i] :
                              (sys_sel[i] ? 1'b1 : pre_tick);              // see R5, see R6, see R10
            assign htick    = sys_sel[i] ? 1'b1 : pre_tick;
            assign split_me = (i == 0) && (md == `QCTA_MODE_SPLIT);
            always @* begin
                nxt_cnt  = cnt_ff;
                nxt_ovf  = 1'b0;
                nxt_hovf = 1'b0;
                if (load_in[i]) begin
                    nxt_cnt = load_value_in;
                end else begin
                    if (run && tick) begin
                        case (md)   // see R2
                            `QCTA_MODE_13BIT: begin
                                nxt_ovf = ({cnt_ff[15:8], cnt_ff[4:0]} == `QCTA_MAX13);
                                {nxt_cnt[15:8], nxt_cnt[4:0]} = {cnt_ff[15:8], cnt_ff[4:0]} + 13'h1;
                            end
                            `QCTA_MODE_16BIT: begin
                                nxt_ovf = (cnt_ff == `QCTA_MAX16);
                                nxt_cnt = cnt_ff + 16'h1;
                            end
                            `QCTA_MODE_8RELOAD: begin
                                nxt_ovf = (cnt_ff[7:0] == `QCTA_MAX8);
                                nxt_cnt[7:0] = nxt_ovf ? cnt_ff[15:8] : cnt_ff[7:0] + 8'h1;
                            end
                            default: begin
                                if (split_me) begin
                                    nxt_ovf = (cnt_ff[7:0] == `QCTA_MAX8);
                                    nxt_cnt[7:0] = cnt_ff[7:0] + 8'h1;
                                end
                            end
                        endcase
                    end
                    // Split high byte borrows timer 1's run bit and flags timer 1's overflow.
                    if (split_me && timer1_run_in && htick) begin
                        nxt_hovf = (cnt_ff[15:8] == `QCTA_MAX8);
                        nxt_cnt[15:8] = cnt_ff[15:8] + 8'h1;
                    end
                end
            end
            always @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    cnt_ff  <= `QCTA_CNT_RST;
                    ovf_ff  <= 1'b0;
                    hovf_ff <= 1'b0;
                end else if (ce_in) begin
                    cnt_ff  <= nxt_cnt;   // see R1
                    ovf_ff  <= nxt_ovf;
                    hovf_ff <= nxt_hovf;
                end
            end
            assign own_ovf[i]      = ovf_ff;
            assign cnt01[16*i+15:16*i] = cnt_ff;
            if (i == 0) begin : g_hovf
                assign split_hi_ovf = hovf_ff;
            end
        end
    endgenerate
    assign ovf_out[0] = own_ovf[0];
    assign ovf_out[1] = split0 ? split_hi_ovf : own_ovf[1];
    // Timers 2 and 3.
    wire [1:0]  osc8_tick;
    wire [1:0]  cmp_tick;
    wire [31:0] cnt23;
    assign osc8_tick = {div8_tick[2], div8_tick[1]};   // see R8, see R9
    assign cmp_tick  = {rise[`QCTA_LN_CMP1], rise[`QCTA_LN_CMP0]};
    genvar j;
    generate
        for (j = 0; j < 2; j = j + 1) begin : g_t23
            reg  [15:0] cnt_ff;
            reg  [15:0] nxt_cnt;
            reg  [15:0] cap_ff;
            reg         cap_evt_ff;
            reg         ovf_hi_ff;
            reg         ovf_lo_ff;
            reg         nxt_hi;
            reg         nxt_lo;
            reg         src_tick;
            wire [15:0] rld;
            wire        cap_mode;
            wire        lo_tick;
            wire        hi_tick;
            assign rld      = t23_reload_in[16*j+15:16*j];
            assign cap_mode = t23_capture_in[j];
            always @* begin
                case (t23_src_sel_in[2*j+1:2*j])
                    `QCTA_SRC_OSC8: src_tick = osc8_tick[j];
                    `QCTA_SRC_CMP:  src_tick = cmp_tick[j];
                    default:        src_tick = tick12;
                endcase
            end
            // In capture the count runs on the system clock path and the source marks the period.
            assign lo_tick = t23_sysclk_lo_in[j] ? 1'b1 : (cap_mode ? tick12 : src_tick);   // see R7
            assign hi_tick = t23_sysclk_hi_in[j] ? 1'b1 : src_tick;
            always @* begin
                nxt_cnt = cnt_ff;
                nxt_hi  = 1'b0;
                nxt_lo  = 1'b0;
                if (load_in[2+j]) begin
                    nxt_cnt = load_value_in;
                end else if (t23_run_in[j]) begin
                    if (t23_split_in[j]) begin   // see R3
                        if (lo_tick) begin
                            nxt_lo = (cnt_ff[7:0] == `QCTA_MAX8);
                            nxt_cnt[7:0] = nxt_lo ? rld[7:0] : cnt_ff[7:0] + 8'h1;
                        end
                        if (hi_tick) begin
                            nxt_hi = (cnt_ff[15:8] == `QCTA_MAX8);
                            nxt_cnt[15:8] = nxt_hi ? rld[15:8] : cnt_ff[15:8] + 8'h1;
                        end
                    end else if (lo_tick) begin
                        nxt_hi  = (cnt_ff == `QCTA_MAX16);
                        nxt_cnt = (nxt_hi && !cap_mode) ? rld : cnt_ff + 16'h1;
                    end
                end
            end
            always @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    cnt_ff     <= `QCTA_CNT_RST;
                    cap_ff     <= `QCTA_CNT_RST;
                    cap_evt_ff <= 1'b0;
                    ovf_hi_ff  <= 1'b0;
                    ovf_lo_ff  <= 1'b0;
                end else if (ce_in) begin
                    cnt_ff     <= nxt_cnt;
                    ovf_hi_ff  <= nxt_hi;
                    ovf_lo_ff  <= nxt_lo;
                    cap_evt_ff <= cap_mode && t23_run_in[j] && src_tick;
                    if (cap_mode && t23_run_in[j] && src_tick) begin
                        cap_ff <= cnt_ff;   // see R4
                    end
                end
            end
            assign cnt23[16*j+15:16*j]        = cnt_ff;
            assign ovf_out[2+j]               = ovf_hi_ff;
            assign t23_ovf_lo_out[j]          = ovf_lo_ff;
            assign t23_capture_out[16*j+15:16*j] = cap_ff;
            assign t23_capture_evt_out[j]     = cap_evt_ff;
        end
    endgenerate
    assign count_out = {cnt23, cnt01};
endmodule

// >>> pkg/qcta_map.vh
// Constants for the quad counter/timer array: divide ratios, mode codes and reset values.
`ifndef QCTA_MAP_VH
`define QCTA_MAP_VH

// Shared prescaler divide ratios for timers 0 and 1.
`define QCTA_DIV_SYS12        12
`define QCTA_DIV_SYS4         4
`define QCTA_DIV_SYS48        48
`define QCTA_DIV_EXT8         8

// Prescale field codes (prescale_sel_hi, prescale_sel_lo).
`define QCTA_PRE_SYS12        2'b00
`define QCTA_PRE_SYS4         2'b01
`define QCTA_PRE_SYS48        2'b10
`define QCTA_PRE_EXT8         2'b11

// Timer 0/1 operating modes.
`define QCTA_MODE_13BIT       2'b00
`define QCTA_MODE_16BIT       2'b01
`define QCTA_MODE_8RELOAD     2'b10
`define QCTA_MODE_SPLIT       2'b11

// Timer 2/3 external clock source codes.
`define QCTA_SRC_SYS12        2'b00
`define QCTA_SRC_OSC8         2'b01
`define QCTA_SRC_CMP          2'b10

// Synchroniser lane positions.
`define QCTA_LN_EV0           0
`define QCTA_LN_EV1           1
`define QCTA_LN_EXT           2
`define QCTA_LN_RTC           3
`define QCTA_LN_XOSC          4
`define QCTA_LN_CMP0          5
`define QCTA_LN_CMP1          6
`define QCTA_LANES            7

// Reset values and terminal counts.
`define QCTA_CNT_RST          16'h0000
`define QCTA_MAX13            13'h1FFF
`define QCTA_MAX8             8'hFF
`define QCTA_MAX16            16'hFFFF

`endif

// >>> bench/qcta_top_asserts.sv
// Concurrent checks on the ports of the quad counter/timer array.
`timescale 1ns/10ps
`include "qcta_map.vh"
module qcta_chk #(
    parameter PRE_W = 6
) (
    input wire        mclk_in,
    input wire        arst_n_in,
    input wire        ce_in,
    input wire [1:0]  t01_mode_in,
    input wire [1:0]  t01_counter_sel_in,
    input wire        timer0_sysclk_select_in,
    input wire        timer0_run_in,
    input wire        timer0_gate_enable_in,
    input wire        ext_gate_input0_in,
    input wire [3:0]  load_in,
    input wire [15:0] load_value_in,
    input wire [1:0]  t23_split_in,
    input wire [1:0]  t23_capture_in,
    input wire [31:0] t23_reload_in,
    input wire [63:0] count_out,
    input wire [3:0]  ovf_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    a_load_wins0: assert property (ce_in && load_in[0] |=> count_out[15:0] == $past(load_value_in))
        else $error("timer 0 load value not taken");
    a_load_wins2: assert property (ce_in && load_in[2] |=> count_out[47:32] == $past(load_value_in))
        else $error("timer 2 load value not taken");
    a_run_hold: assert property (ce_in && !timer0_run_in && !load_in[0] |=> $stable(count_out[7:0]))
        else $error("timer 0 moved while stopped");
    a_gate_blocks: assert property ((ce_in && timer0_gate_enable_in && !ext_gate_input0_in && !load_in[0]
        && t01_mode_in != `QCTA_MODE_SPLIT)[*6] |-> $stable(count_out[15:0])) else $error("gate did not stop timer 0");
    a_wrap_sixteen: assert property (ovf_out[0] && $past(t01_mode_in) == `QCTA_MODE_16BIT
        |-> count_out[15:0] == 16'h0000) else $error("16-bit overflow without wrap to zero");
    a_wrap_thirteen: assert property (ovf_out[0] && $past(t01_mode_in) == `QCTA_MODE_13BIT
        |-> count_out[15:8] == 8'h00 && count_out[4:0] == 5'h00) else $error("13-bit overflow without wrap");
    a_ovf_single: assert property (ovf_out[0] && ce_in && t01_mode_in == `QCTA_MODE_16BIT |=> !ovf_out[0])
        else $error("overflow pulse longer than one cycle");
    a_ce_freeze: assert property (!ce_in |=> count_out == $past(count_out))
        else $error("counts moved with clock enable low");
    a_sysclk_step: assert property (ce_in && t01_mode_in == `QCTA_MODE_16BIT && timer0_sysclk_select_in
        && !t01_counter_sel_in[0] && timer0_run_in && !timer0_gate_enable_in && !load_in[0]
        |=> count_out[15:0] == $past(count_out[15:0]) + 16'h0001) else $error("timer 0 missed a system clock step");
    a_t2_reload: assert property (ovf_out[2] && !t23_split_in[0] && !t23_capture_in[0]
        |-> count_out[47:32] == $past(t23_reload_in[15:0])) else $error("timer 2 did not reload");
    c_ovf0: cover property (ovf_out[0]);
    c_ovf2: cover property (ovf_out[2]);
    c_freeze: cover property (!ce_in);
endmodule
bind qcta_top qcta_chk #(.PRE_W(PRE_W)) u_chk (.mclk_in, .arst_n_in, .ce_in, .t01_mode_in, .t01_counter_sel_in,
    .timer0_sysclk_select_in, .timer0_run_in, .timer0_gate_enable_in, .ext_gate_input0_in, .load_in,
    .load_value_in, .t23_split_in, .t23_capture_in, .t23_reload_in, .count_out, .ovf_out);

// >>> bench/qcta_evsrc.sv
// Event source model: counter pin pulses plus free-running oscillator and comparator lines.
`timescale 1ns/10ps
module qcta_evsrc (
    input  wire mclk_in,
    output reg  pin_out,
    output reg  osc_out,
    output reg  cmp_out
);
    initial begin
        pin_out = 1'b1;
        osc_out = 1'b0;
        cmp_out = 1'b0;
        #1.3;
        fork
            forever #8 osc_out = ~osc_out;
            forever #12 cmp_out = ~cmp_out;
        join
    end
    // Each level lasts two full system clock cycles, the fastest rate that must be counted.
    task pulses(input integer n);
        integer i;
        begin
            @(posedge mclk_in);
            for (i = 0; i < n; i = i + 1) begin
                #1 pin_out = 1'b0;
                repeat (2) @(posedge mclk_in);
                #1 pin_out = 1'b1;
                repeat (2) @(posedge mclk_in);
            end
        end
    endtask
endmodule

// >>> bench/tb_qcta_top.sv
// Self-checking bench for the quad counter/timer array.
`timescale 1ns/10ps
`include "qcta_map.vh"
module tb_qcta_top;
    reg        mclk_in = 1'b0, arst_n_in = 1'b0, ce_in = 1'b1;
    reg        prescale_sel_hi_in = 1'b0, prescale_sel_lo_in = 1'b0;
    reg        timer0_sysclk_select_in = 1'b1, timer1_sysclk_select_in = 1'b1;
    reg [1:0]  t01_mode_in = `QCTA_MODE_16BIT, t1_mode_in = `QCTA_MODE_16BIT, t01_counter_sel_in = 2'h0;
    reg        timer0_run_in = 1'b0, timer1_run_in = 1'b0, timer0_gate_enable_in = 1'b0, ext_gate_input0_in = 1'b0;
    reg [3:0]  load_in = 4'h0, t23_src_sel_in = 4'h0;
    reg [15:0] load_value_in = 16'h0000, p, e;
    reg [1:0]  t23_run_in = 2'h0, t23_sysclk_lo_in = 2'h0, t23_split_in = 2'h0, t23_capture_in = 2'h0;
    reg [31:0] t23_reload_in = 32'h0000_0000;
    wire [63:0] count_out;
    wire [3:0]  ovf_out;
    wire        pin, osc, cmp;
    wire [1:0]  ovf_lo, cap_evt;
    wire [31:0] cap_val;
    integer     fails = 0, checks = 0, cycles = 0, k;
    initial forever #2 mclk_in = ~mclk_in;
    qcta_evsrc src (.mclk_in, .pin_out(pin), .osc_out(osc), .cmp_out(cmp));
    qcta_top #(.PRE_W(6)) uut (.mclk_in, .arst_n_in, .ce_in, .timer0_event_pin_in(pin), .timer1_event_pin_in(pin),
        .ext_clk_in(osc), .rtc_osc_in(osc), .xosc_clk_in(osc), .cmp0_out_in(cmp), .cmp1_out_in(cmp),
        .prescale_sel_hi_in, .prescale_sel_lo_in, .timer0_sysclk_select_in, .timer1_sysclk_select_in, .t01_mode_in,
        .t1_mode_in, .t01_counter_sel_in, .timer0_run_in, .timer1_run_in, .timer0_gate_enable_in,
        .timer1_gate_enable_in(1'b0), .ext_gate_input0_in, .ext_gate_input1_in(1'b0), .load_in, .load_value_in,
        .t23_run_in, .t23_split_in, .t23_capture_in, .t23_sysclk_lo_in, .t23_sysclk_hi_in(2'h0),
        .t23_src_sel_in, .t23_reload_in, .count_out, .ovf_out, .t23_ovf_lo_out(ovf_lo), .t23_capture_out(cap_val),
        .t23_capture_evt_out(cap_evt));
    function [15:0] cnt(input integer t);
        cnt = count_out[16 * t +: 16];
    endfunction
    task cmp16(input [15:0] got, input [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge mclk_in);
    endtask
    task ld(input integer t, input [15:0] v);
        begin
            load_in[t] = 1'b1;
            load_value_in = v;
            tick(1);
            load_in[t] = 1'b0;
        end
    endtask
    // Measures the cycles between count steps, skipping the first two intervals and timing the third.
    task gap(input integer t, input [15:0] exp);
        integer n, j;
        begin
            for (j = 0; j < 3; j = j + 1) begin
                n = 0;
                p = cnt(t);
                while (cnt(t) === p && n < 300) begin
                    tick(1);
                    n = n + 1;
                end
            end
            cmp16(n[15:0], exp);
        end
    endtask
    task wrap01(input [1:0] mode, input [15:0] v, input [15:0] e1, input [15:0] e2);
        begin
            t01_mode_in = mode;
            ld(0, v);
            timer0_run_in = 1'b1;
            tick(1);
            cmp16(cnt(0), e1);
            cmp16({15'h0000, ovf_out[0]}, 16'h0000);
            tick(1);
            cmp16(cnt(0), e2);
            cmp16({15'h0000, ovf_out[0]}, 16'h0001);
            timer0_run_in = 1'b0;
        end
    endtask
    // Waits for a timer 2 capture strobe and returns the captured count.
    task capwait(output [15:0] v);
        integer n;
        begin
            n = 0;
            while (cap_evt[0] !== 1'b1 && n < 20) begin
                tick(1);
                n = n + 1;
            end
            v = cap_val[15:0];
        end
    endtask
    task conclude;
        begin
            $display("checks=%0d fails=%0d", checks, fails);
            if (fails == 0 && checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge mclk_in) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            conclude;
        end
    end
    initial begin
        tick(8);
        cmp16(cnt(0) | cnt(1) | cnt(2) | cnt(3), 16'h0000);
        arst_n_in = 1'b1;
        $display("test reset done");
        wrap01(`QCTA_MODE_16BIT, 16'hfffe, 16'hffff, 16'h0000);
        wrap01(`QCTA_MODE_13BIT, 16'hff1e, 16'hff1f, 16'h0000);
        wrap01(`QCTA_MODE_8RELOAD, 16'h80fe, 16'h80ff, 16'h8080);
        t01_mode_in = `QCTA_MODE_16BIT;
        $display("test wrap done");
        t01_counter_sel_in = 2'h3;
        ld(0, 16'h0000);
        ld(1, 16'h0000);
        timer0_run_in = 1'b1;
        timer1_run_in = 1'b1;
        src.pulses(5);
        tick(6);
        cmp16(cnt(0), 16'h0005);
        cmp16(cnt(1), 16'h0005);
        timer0_run_in = 1'b0;
        src.pulses(3);
        tick(6);
        cmp16(cnt(0), 16'h0005);
        t01_counter_sel_in = 2'h0;
        $display("test counter done");
        timer0_gate_enable_in = 1'b1;
        ld(0, 16'h0000);
        timer0_run_in = 1'b1;
        tick(10);
        cmp16(cnt(0), 16'h0000);
        ext_gate_input0_in = 1'b1;
        tick(8);
        e = cnt(0);
        tick(5);
        cmp16(cnt(0), e + 16'h0005);
        e = cnt(0);
        ce_in = 1'b0;
        tick(4);
        cmp16(cnt(0), e);
        ce_in = 1'b1;
        timer0_gate_enable_in = 1'b0;
        $display("test gate done");
        timer0_sysclk_select_in = 1'b0;
        {prescale_sel_hi_in, prescale_sel_lo_in} = `QCTA_PRE_SYS12;
        gap(0, 16'h000c);
        {prescale_sel_hi_in, prescale_sel_lo_in} = `QCTA_PRE_SYS4;
        gap(0, 16'h0004);
        {prescale_sel_hi_in, prescale_sel_lo_in} = `QCTA_PRE_SYS48;
        gap(0, 16'h0030);
        {prescale_sel_hi_in, prescale_sel_lo_in} = `QCTA_PRE_EXT8;
        gap(0, 16'h0020);
        timer0_sysclk_select_in = 1'b1;
        gap(0, 16'h0001);
        timer0_run_in = 1'b0;
        $display("test prescale done");
        t01_mode_in = `QCTA_MODE_SPLIT;
        t1_mode_in = `QCTA_MODE_SPLIT;
        timer1_run_in = 1'b0;
        ld(0, 16'hfefe);
        e = cnt(1);
        timer0_run_in = 1'b1;
        tick(1);
        cmp16(cnt(0), 16'hfeff);
        timer1_run_in = 1'b1;
        tick(1);
        cmp16(cnt(0), 16'hff00);
        cmp16({14'h0000, ovf_out[1:0]}, 16'h0001);
        tick(1);
        cmp16(cnt(0), 16'h0001);
        cmp16({14'h0000, ovf_out[1:0]}, 16'h0002);
        cmp16(cnt(1), e);
        timer0_run_in = 1'b0;
        t01_mode_in = `QCTA_MODE_16BIT;
        $display("test split timer done");
        t23_reload_in = 32'h0000_fffc;
        t23_sysclk_lo_in = 2'h1;
        ld(2, 16'hfffe);
        t23_run_in = 2'h1;
        tick(1);
        cmp16(cnt(2), 16'hffff);
        tick(1);
        cmp16(cnt(2), 16'hfffc);
        cmp16({15'h0000, ovf_out[2]}, 16'h0001);
        t23_reload_in = 32'h0000_0000;
        t23_sysclk_lo_in = 2'h0;
        t23_run_in = 2'h3;
        for (k = 0; k < 4; k = k + 1) begin
            t23_src_sel_in = {k[1:0], k[1:0]};
            e = (k == 1) ? 16'h0020 : (k == 2) ? 16'h0006 : 16'h000c;
            gap(2, e);
            gap(3, e);
        end
        $display("test auto reload done");
        t23_run_in = 2'h0;
        t23_reload_in = 32'h0000_2010;
        t23_split_in = 2'h1;
        t23_sysclk_lo_in = 2'h1;
        ld(2, 16'hfffe);
        t23_run_in = 2'h1;
        tick(1);
        cmp16({8'h00, count_out[39:32]}, 16'h00ff);
        tick(1);
        cmp16({8'h00, count_out[39:32]}, 16'h0010);
        cmp16({15'h0000, ovf_lo[0]}, 16'h0001);
        tick(10);
        cmp16(cnt(2), 16'h201a);
        $display("test split reload done");
        t23_split_in = 2'h0;
        t23_capture_in = 2'h1;
        t23_src_sel_in = 4'h2;
        capwait(p);
        tick(1);
        cmp16({15'h0000, cap_evt[0]}, 16'h0000);
        capwait(e);
        cmp16(e - p, 16'h0006);
        $display("test capture done");
        conclude;
    end
endmodule
